/* inc/ref_select_pkg.sv */
package ref_select_pkg;

  localparam int unsigned SEL_W         = 3;
  localparam int unsigned RES_W         = 12;
  localparam int unsigned CH_W          = 4;
  localparam int unsigned HI_BIT        = 2;
  localparam int unsigned ROLE_BIT      = 1;
  localparam int unsigned KEEP_BIT      = 0;
  localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;
  localparam logic [1:0] SRC_SUPPLY     = 2'h0;
  localparam logic [1:0] SRC_EXTERNAL   = 2'h1;
  localparam logic [1:0] SRC_INT_OUT    = 2'h3;
  localparam logic [CH_W-1:0] CH_TWO    = 4'h2;
  localparam logic [CH_W-1:0] CH_TEN    = 4'hA;

  // Wake-up time in microseconds and the clock rate
  localparam int unsigned WAKE_US       = 10000;
  localparam int unsigned CLK_MHZ       = 50;
  localparam int unsigned WAKE_CYCLES   = WAKE_US * CLK_MHZ;
  localparam int unsigned WAKE_W        = 20;

  typedef enum logic [1:0] {
    REF_SUPPLY,
    REF_EXTERNAL,
    REF_INTERNAL
  } ref_src_t;

  typedef struct packed {
    ref_src_t   source;
    logic       pinIsRef;
    logic       pinDriveOut;
    logic       intRefOn;
  } ref_decode_t;

endpackage : ref_select_pkg

/* core/adc_reference_select_and_coding.sv */
`timescale 1ns/1ps
module adc_reference_select_and_coding #(
  parameter int unsigned WAKE_CYCLES = ref_select_pkg::WAKE_CYCLES
) (
  input  wire logic                                clk,
  input  wire logic                                reset,
  input  wire logic                                setupValid,
  input  wire logic [ref_select_pkg::SEL_W-1:0]    setupSel,
  input  wire logic                                shutdown,
  input  wire logic                                twelveChannel,
  input  wire logic                                singleEndedScan,
  input  wire logic [ref_select_pkg::CH_W-1:0]     requestedTop,
  input  wire logic                                diffUsesSharedPin,
  input  wire logic                                bipolar,
  input  wire logic                                rawValid,
  input  wire logic [ref_select_pkg::RES_W-1:0]    rawResult,
  output logic [ref_select_pkg::SEL_W-1:0]         selField,
  output ref_select_pkg::ref_decode_t              refDecode,
  output logic                                     refReady,
  output logic                                     refOutDriveEn,
  output logic                                     sharedPinAsGround,
  output logic [ref_select_pkg::CH_W-1:0]          scanTopChannel,
  output logic                                     resultValid,
  output logic [ref_select_pkg::RES_W-1:0]         result
);

  // ==========================================================
  // Decode
  // ==========================================================
  function automatic ref_select_pkg::ref_decode_t decodeSel(
    input logic [ref_select_pkg::SEL_W-1:0] s
  );
    ref_select_pkg::ref_decode_t d;
    d.source      = s[ref_select_pkg::HI_BIT] ? ref_select_pkg::REF_INTERNAL :
                    (s[ref_select_pkg::ROLE_BIT] ? ref_select_pkg::REF_EXTERNAL
                                                 : ref_select_pkg::REF_SUPPLY);
    d.pinIsRef    = s[ref_select_pkg::ROLE_BIT];
    d.pinDriveOut = (s[ref_select_pkg::HI_BIT:ref_select_pkg::ROLE_BIT]
                     == ref_select_pkg::SRC_INT_OUT);
    d.intRefOn    = s[ref_select_pkg::HI_BIT] & s[ref_select_pkg::KEEP_BIT];
    return d;
  endfunction : decodeSel

  // ==========================================================
  // Setup field
  // ==========================================================
  logic [ref_select_pkg::SEL_W-1:0] sel_reg;
  logic [ref_select_pkg::SEL_W-1:0] sel_next;

  always_comb begin
    sel_next = sel_reg;
    if (setupValid) begin
      sel_next = setupSel;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sel_reg <= ref_select_pkg::SEL_RESET;
    end else begin
      sel_reg <= sel_next;
    end
  end

  ref_select_pkg::ref_decode_t dec;
  assign dec = decodeSel(sel_reg);

  // ==========================================================
  // Wake-up timer
  // ==========================================================
  // Reference power follows only the field, never shutdown, since wake-up is slow
  logic                              wasOn_reg;
  logic                              wasOn_next;
  logic [ref_select_pkg::WAKE_W-1:0] wake_reg;
  logic [ref_select_pkg::WAKE_W-1:0] wake_next;
  logic                              ready_reg;
  logic                              ready_next;

  always_comb begin
    wasOn_next = dec.intRefOn;
    wake_next  = wake_reg;
    ready_next = ready_reg;
    if (!dec.intRefOn) begin
      wake_next  = '0;
      ready_next = (dec.source != ref_select_pkg::REF_INTERNAL);
    end else if (!wasOn_reg) begin
      wake_next  = '0;
      ready_next = 1'b0;
    end else if (!ready_reg) begin
      if (wake_reg == ref_select_pkg::WAKE_W'(WAKE_CYCLES - 1)) begin
        ready_next = 1'b1;
      end else begin
        wake_next = wake_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wasOn_reg <= 1'b0;
      wake_reg  <= '0;
      ready_reg <= 1'b1;
    end else begin
      wasOn_reg <= wasOn_next;
      wake_reg  <= wake_next;
      ready_reg <= ready_next;
    end
  end

  // ==========================================================
  // Pin role, limiter and result coding
  // ==========================================================
  logic [ref_select_pkg::CH_W-1:0]  top_reg;
  logic [ref_select_pkg::CH_W-1:0]  top_next;
  logic [ref_select_pkg::RES_W-1:0] res_reg;
  logic [ref_select_pkg::RES_W-1:0] res_next;
  logic                             rv_reg;
  logic                             rv_next;
  logic [ref_select_pkg::CH_W-1:0]  cap;

  always_comb begin
    cap      = twelveChannel ? ref_select_pkg::CH_TEN : ref_select_pkg::CH_TWO;
    top_next = requestedTop;
    if (singleEndedScan && dec.pinIsRef && requestedTop > cap) begin
      top_next = cap;
    end
    rv_next  = rawValid;
    res_next = res_reg;
    if (rawValid) begin
      // Core delivers offset binary; bipolar flips the sign bit
      res_next = bipolar ? {~rawResult[ref_select_pkg::RES_W-1],
                            rawResult[ref_select_pkg::RES_W-2:0]}
                         : rawResult;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      top_reg <= '0;
      res_reg <= '0;
      rv_reg  <= 1'b0;
    end else begin
      top_reg <= top_next;
      res_reg <= res_next;
      rv_reg  <= rv_next;
    end
  end

  assign selField          = sel_reg;
  assign refDecode         = dec;
  assign refReady          = ready_reg;
  assign refOutDriveEn     = dec.pinDriveOut & ~shutdown;
  assign sharedPinAsGround = dec.pinIsRef & diffUsesSharedPin;
  assign scanTopChannel    = top_reg;
  assign resultValid       = rv_reg;
  assign result            = res_reg;

  // ==========================================================
  // Checks
  // ==========================================================
  sequence s_newSetup;
    setupValid;
  endsequence

  property p_selUpdate;
    @(posedge clk) disable iff (reset)
    s_newSetup |=> (selField == $past(setupSel));
  endproperty
  a_selUpdate: assert property (p_selUpdate) else $error("field not updated");

  property p_selHold;
    @(posedge clk) disable iff (reset)
    !setupValid |=> $stable(selField);
  endproperty
  a_selHold: assert property (p_selHold) else $error("field changed unasked");

  property p_intOn;
    @(posedge clk) disable iff (reset)
    refDecode.intRefOn == (selField[2] && selField[0]);
  endproperty
  a_intOn: assert property (p_intOn) else $error("reference power wrong");

  property p_driveOff;
    @(posedge clk) disable iff (reset)
    shutdown |-> !refOutDriveEn;
  endproperty
  a_driveOff: assert property (p_driveOff) else $error("driver on in shutdown");

  property p_notReadyOnPower;
    @(posedge clk) disable iff (reset)
    $rose(refDecode.intRefOn) |=> !refReady;
  endproperty
  a_notReadyOnPower: assert property (p_notReadyOnPower) else $error("ready too soon");

  property p_noWait;
    @(posedge clk) disable iff (reset)
    (refDecode.source != ref_select_pkg::REF_INTERNAL) |=>
      (refReady || $past(refDecode.source) != refDecode.source || $past(setupValid));
  endproperty
  a_noWait: assert property (p_noWait) else $error("wait with outside ref");

  property p_cap;
    @(posedge clk) disable iff (reset)
    (singleEndedScan && refDecode.pinIsRef && !twelveChannel) |=> scanTopChannel <= 4'h2;
  endproperty
  a_cap: assert property (p_cap) else $error("scan cap exceeded");

  property p_coding;
    @(posedge clk) disable iff (reset)
    (rawValid && bipolar) |=> (result[11] != $past(rawResult[11])) && resultValid;
  endproperty
  a_coding: assert property (p_coding) else $error("bipolar coding wrong");

  property p_ground;
    @(posedge clk) disable iff (reset)
    (diffUsesSharedPin && selField[1]) |-> sharedPinAsGround;
  endproperty
  a_ground: assert property (p_ground) else $error("shared pin not ground");

  property p_groundOff;
    @(posedge clk) disable iff (reset)
    !refDecode.pinIsRef |-> !sharedPinAsGround;
  endproperty
  a_groundOff: assert property (p_groundOff) else $error("analog pin grounded");

  property p_resetField;
    @(posedge clk)
    reset |=> (selField == ref_select_pkg::SEL_RESET) && refReady && !resultValid;
  endproperty
  a_resetField: assert property (p_resetField) else $error("reset state wrong");

  property p_source;
    @(posedge clk) disable iff (reset)
    selField[ref_select_pkg::HI_BIT] |-> refDecode.source == ref_select_pkg::REF_INTERNAL;
  endproperty
  a_source: assert property (p_source) else $error("source decode wrong");

  property p_pinRole;
    @(posedge clk) disable iff (reset)
    refDecode.pinIsRef == selField[ref_select_pkg::ROLE_BIT];
  endproperty
  a_pinRole: assert property (p_pinRole) else $error("pin role wrong");

  property p_driveOn;
    @(posedge clk) disable iff (reset)
    (selField[ref_select_pkg::HI_BIT] && selField[ref_select_pkg::ROLE_BIT] && !shutdown)
      |-> refOutDriveEn;
  endproperty
  a_driveOn: assert property (p_driveOn) else $error("reference not driven out");

  property p_keepOn;
    @(posedge clk) disable iff (reset)
    (refDecode.intRefOn && !setupValid) |=> refDecode.intRefOn;
  endproperty
  a_keepOn: assert property (p_keepOn) else $error("reference dropped");

  // Wake-up is two steps: counting with ready low, then ready one cycle after the last count
  sequence s_wakeCounting;
    refDecode.intRefOn && wasOn_reg && !refReady &&
      (wake_reg != ref_select_pkg::WAKE_W'(WAKE_CYCLES - 1));
  endsequence

  sequence s_wakeLast;
    refDecode.intRefOn && wasOn_reg && !refReady &&
      (wake_reg == ref_select_pkg::WAKE_W'(WAKE_CYCLES - 1));
  endsequence

  property p_wakeHold;
    @(posedge clk) disable iff (reset)
    s_wakeCounting |=> !refReady;
  endproperty
  a_wakeHold: assert property (p_wakeHold) else $error("ready before wake-up");

  property p_wakeDone;
    @(posedge clk) disable iff (reset)
    s_wakeLast |=> refReady;
  endproperty
  a_wakeDone: assert property (p_wakeDone) else $error("ready late");

  property p_offNotReady;
    @(posedge clk) disable iff (reset)
    (refDecode.source == ref_select_pkg::REF_INTERNAL && !refDecode.intRefOn) |=> !refReady;
  endproperty
  a_offNotReady: assert property (p_offNotReady) else $error("ready while off");

  property p_limitPass;
    @(posedge clk) disable iff (reset)
    !(singleEndedScan && refDecode.pinIsRef) |=> scanTopChannel == $past(requestedTop);
  endproperty
  a_limitPass: assert property (p_limitPass) else $error("top changed unasked");

  property p_capTen;
    @(posedge clk) disable iff (reset)
    (singleEndedScan && refDecode.pinIsRef && twelveChannel)
      |=> scanTopChannel <= ref_select_pkg::CH_TEN;
  endproperty
  a_capTen: assert property (p_capTen) else $error("wide scan cap exceeded");

  property p_unipolar;
    @(posedge clk) disable iff (reset)
    (rawValid && !bipolar) |=> result == $past(rawResult);
  endproperty
  a_unipolar: assert property (p_unipolar) else $error("binary coding wrong");

  property p_validPulse;
    @(posedge clk) disable iff (reset)
    !rawValid |=> !resultValid;
  endproperty
  a_validPulse: assert property (p_validPulse) else $error("stray result valid");

endmodule : adc_reference_select_and_coding

/* sim/setup_master.sv */
`timescale 1ns/1ps
// ==========================================
// Two-wire master: hands over acknowledged setup bytes
module setup_master (
  input  wire logic                             clk,
  output logic                                  setupValid,
  output logic [ref_select_pkg::SEL_W-1:0]      setupSel
);
  initial begin
    setupValid = 1'b0;
    setupSel   = 3'h0;
  end

  // Idle gap makes the master prompt or slow; the field is scrambled once released
  task automatic send(input logic [2:0] sel, input int gap);
    repeat (gap) @(negedge clk);
    setupSel   = sel;
    setupValid = 1'b1;
    @(negedge clk);
    setupValid = 1'b0;
    setupSel   = ~sel;
  endtask : send
endmodule : setup_master

/* sim/testbench.sv */
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED %0t %s", $time, m); end end
module testbench;
  localparam int W = 8;
  logic clk = 1'b0;
  logic reset, shutdown, twelveChannel, singleEndedScan, diffUsesSharedPin, bipolar, rawValid;
  logic [3:0] requestedTop, scanTopChannel;
  logic [11:0] rawResult, result, raw;
  logic [2:0] setupSel, selField, sel;
  logic setupValid, refReady, refOutDriveEn, sharedPinAsGround, resultValid;
  ref_select_pkg::ref_decode_t refDecode;
  int error_cnt = 0;
  int n_tests = 0;
  int cnt;
  logic [3:0] cap;

  always #10 clk = ~clk;

  setup_master u_master (.clk(clk), .setupValid(setupValid), .setupSel(setupSel));
  adc_reference_select_and_coding #(.WAKE_CYCLES(W)) u_dut (
    .clk(clk), .reset(reset), .setupValid(setupValid), .setupSel(setupSel),
    .shutdown(shutdown), .twelveChannel(twelveChannel), .singleEndedScan(singleEndedScan),
    .requestedTop(requestedTop), .diffUsesSharedPin(diffUsesSharedPin), .bipolar(bipolar),
    .rawValid(rawValid), .rawResult(rawResult), .selField(selField), .refDecode(refDecode),
    .refReady(refReady), .refOutDriveEn(refOutDriveEn), .sharedPinAsGround(sharedPinAsGround),
    .scanTopChannel(scanTopChannel), .resultValid(resultValid), .result(result));

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // Counts falling edges until the reference reports ready; a hang ends the run
  task automatic wait_ready(output int n);
    for (n = 1; n <= 64; n++) begin
      @(negedge clk);
      if (refReady === 1'b1) return;
    end
    error_cnt++;
    $display("CHECK FAILED %0t reference never ready", $time);
    end_of_test();
  endtask : wait_ready

  function automatic ref_select_pkg::ref_src_t exp_src(input logic [2:0] s);
    if (s[2]) return ref_select_pkg::REF_INTERNAL;
    return s[1] ? ref_select_pkg::REF_EXTERNAL : ref_select_pkg::REF_SUPPLY;
  endfunction : exp_src

  // ==========================================
  // Main sequence
  initial begin
    {reset, shutdown, twelveChannel, singleEndedScan, diffUsesSharedPin, bipolar} = 6'h20;
    {rawValid, requestedTop, rawResult} = 17'h0;
    void'($urandom(32'h714E));
    repeat (5) @(negedge clk);
    reset = 1'b0;
    `CHK(selField, 3'h0, "reset field")
    `CHK(refDecode.source, ref_select_pkg::REF_SUPPLY, "reset source")
    `CHK(refDecode.pinIsRef, 1'b0, "reset pin role")
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      sel = k[2:0];
      shutdown = 1'($urandom);
      diffUsesSharedPin = 1'($urandom);
      u_master.send(sel, k % 3);
      `CHK(selField, sel, "field update")
      `CHK(refDecode.source, exp_src(sel), "source")
      `CHK(refDecode.pinIsRef, sel[1], "pin role")
      `CHK(refDecode.intRefOn, sel[2] & sel[0], "ref power")
      `CHK(refDecode.pinDriveOut, sel[2] & sel[1], "drive out")
      `CHK(refOutDriveEn, sel[2] & sel[1] & ~shutdown, "shutdown hi-z")
      `CHK(sharedPinAsGround, sel[1] & diffUsesSharedPin, "pin as ground")
      if (sel[2] & sel[0]) begin
        wait_ready(cnt);
        `CHK(cnt >= W - 1 && cnt <= W + 2, 1'b1, "wake delay")
      end else begin
        @(negedge clk);
        `CHK(refReady, ~sel[2], "ready level")
      end
    end
    $display("test codes done");
    // Field 7 stays on through shutdown and stray field values
    shutdown = 1'b1;
    repeat (4) @(negedge clk);
    `CHK(selField, 3'h7, "field held")
    `CHK(refDecode.intRefOn, 1'b1, "ref kept on")
    `CHK(refReady, 1'b1, "ready kept")
    $display("test keep-on done");
    singleEndedScan = 1'b1;
    for (int k = 0; k < 24; k++) begin
      twelveChannel = 1'($urandom);
      requestedTop = (k < 2) ? 4'hF : 4'($urandom);
      singleEndedScan = (k < 4) ? 1'b1 : 1'($urandom);
      cap = twelveChannel ? ref_select_pkg::CH_TEN : ref_select_pkg::CH_TWO;
      @(negedge clk);
      `CHK(scanTopChannel, (singleEndedScan && requestedTop > cap) ? cap : requestedTop, "cap")
    end
    $display("test limiter done");
    for (int k = 0; k < 24; k++) begin
      raw = (k < 4) ? 12'(12'hFFF * (k & 1) ^ (12'h800 * (k >> 1))) : 12'($urandom);
      bipolar = 1'($urandom);
      rawResult = raw;
      rawValid = 1'b1;
      @(negedge clk);
      `CHK(resultValid, 1'b1, "result valid")
      `CHK(result, bipolar ? {~raw[11], raw[10:0]} : raw, "coding")
      rawValid = 1'b0;
      rawResult = ~raw;
      @(negedge clk);
      `CHK(resultValid, 1'b0, "valid pulse")
      `CHK(result, bipolar ? {~raw[11], raw[10:0]} : raw, "result held")
    end
    $display("test coding done");
    end_of_test();
  end
endmodule : testbench
